// ### rtl/fault_class_if.sv
`timescale 1ns/100ps
interface fault_class_if;
  import fault_pkg::*;
  logic [7:0] ftype;
  logic [7:0] fsub;
  when_type   when_fault;
  logic       rip_valid;
  logic       kill_dest;
  logic       is_trace;
  logic       mode_gated;
  modport core (output ftype, output fsub, input when_fault, input rip_valid,
                input kill_dest, input is_trace, input mode_gated);
  modport unit (input ftype, input fsub, output when_fault, output rip_valid,
                output kill_dest, output is_trace, output mode_gated);
endinterface

// ### rtl/fault_classifier.sv
`timescale 1ns/100ps
module fault_classifier (
  fault_class_if.unit cls
);
  import fault_pkg::*;

  // ---------------------------------------------------------------
  // Timing class and pointer validity
  // ---------------------------------------------------------------
  always_comb begin
    cls.when_fault = WHEN_BEFORE;
    cls.rip_valid  = 1'b0;
    cls.kill_dest  = 1'b1;
    cls.is_trace   = 1'b0;
    cls.mode_gated = 1'b0;
    case (cls.ftype)
      FT_TRACE: begin
        cls.when_fault = WHEN_AFTER;
        cls.rip_valid  = 1'b1;
        cls.kill_dest  = 1'b0;
        cls.is_trace   = 1'b1;
        // Breakpoint and mark traces ignore mode bits
        cls.mode_gated = !(cls.fsub == SUB_HW_BREAK || cls.fsub == SUB_MARK);
      end
      FT_ARITH: begin
        if (cls.fsub == SUB_OVERFLOW) begin
          cls.when_fault = WHEN_AFTER;
          cls.rip_valid  = 1'b1;
          cls.kill_dest  = 1'b0;
        end else begin
          cls.rip_valid  = (cls.fsub == SUB_ZERO_DIV);
        end
      end
      FT_OPERATION: begin
        if (cls.fsub == SUB_UNALIGNED) begin
          cls.when_fault = WHEN_DURING;
          cls.kill_dest  = 1'b0;
        end
      end
      FT_CONSTRAINT: begin
        cls.when_fault = WHEN_DURING;
        cls.kill_dest  = 1'b0;
      end
      default: begin
        cls.when_fault = WHEN_BEFORE;
      end
    endcase
  end
endmodule

// ### rtl/fault_dispatch.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module fault_dispatch (
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  input  wire logic [fault_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  output logic                               commit_dest_r,
  output logic                               commit_mem_r,
  output logic                               handler_super_r,
  output logic                               dispatch_r
);
  import fault_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  state_type   state_r;
  logic [31:0] ctrl_r;
  logic [31:0] fault_r;
  logic [31:0] frame_r;
  logic [31:0] prev_frame_r;
  logic [31:0] saved_return_pointer;
  logic [31:0] next_ip_r;
  logic [31:0] entry_r;
  logic [31:0] saved_ctrl_r;
  logic [2:0]  ret_type_r;
  logic        rip_valid_r;
  logic        pending_trace_r;
  logic        unal_mask_r;
  logic        cfg_loaded_r;
  logic        imprecise_sync_r;
  logic        dropped_r;
  logic        wr_take;
  logic [31:0] fault_view;
  logic        go_fault;
  logic        go_ret;
  logic        raise;
  logic [31:0] rip_calc;

  fault_class_if cls ();

  // Gate on the word being written, not the stale one
  assign fault_view = go_fault ? avs_writedata : fault_r;
  assign cls.ftype  = fault_view[TYPE_LSB +: TYPE_W];
  assign cls.fsub   = fault_view[SUB_LSB +: SUB_W];

  fault_classifier u_cls (
    .cls (cls)
  );

  fault_rip_calc u_rip (
    .sel_next (cls.when_fault == WHEN_AFTER),
    .fault_ip (next_ip_r - 32'h0000_0004),
    .next_ip  (next_ip_r),
    .rip      (rip_calc)
  );

  function automatic logic is_imprecise(input logic [7:0] t);
    return t == FT_OPERATION || t == FT_CONSTRAINT || t == FT_ARITH || t == FT_TYPE;
  endfunction

  // ---------------------------------------------------------------
  // Fault gating
  // ---------------------------------------------------------------
  always_comb begin
    raise = 1'b1;
    if (cls.ftype == FT_ARITH && cls.fsub == SUB_OVERFLOW && ctrl_r[BIT_OVF_MASK])
      raise = 1'b0;
    if (cls.is_trace && !ctrl_r[BIT_TRACE_EN])
      raise = 1'b0;
    if (cls.is_trace && cls.mode_gated && !(|(ctrl_r[TMODE_LSB +: TMODE_W] &
        fault_view[TM_LSB +: TMODE_W])))
      raise = 1'b0;
    if (cls.ftype == FT_OPERATION && cls.fsub == SUB_UNALIGNED && unal_mask_r)
      raise = 1'b0;
  end

  assign wr_take  = avs_write && !avs_waitrequest;
  assign go_fault = wr_take && avs_address == OFS_FAULT && state_r == ST_IDLE;
  assign go_ret   = wr_take && avs_address == OFS_RET && state_r == ST_HANDLER;

  // ---------------------------------------------------------------
  // Bus slave: one wait cycle per access
  // ---------------------------------------------------------------
  // High while idle, so the first cycle of any access waits from a flop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // Loaded in the wait cycle, so it stands when waitrequest drops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        OFS_CTRL:    avs_readdata <= ctrl_r;
        OFS_FAULT:   avs_readdata <= fault_r;
        OFS_STATUS:  avs_readdata <= {22'h0, unal_mask_r, imprecise_sync_r, dropped_r,
                                      pending_trace_r, rip_valid_r, ret_type_r,
                                      state_r};
        OFS_FRAME:   avs_readdata <= frame_r;
        OFS_PREV_PTR: avs_readdata <= prev_frame_r + RET_PTR_OFS;
        OFS_NEXTIP:  avs_readdata <= next_ip_r;
        OFS_ENTRY:   avs_readdata <= entry_r;
        OFS_RET:     avs_readdata <= saved_return_pointer;
        default:     avs_readdata <= UNMAPPED_DATA;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Software writable setup
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fault_r <= 32'h0000_0000;
    end else if (go_fault) begin
      // Kept even when gated off, so software sees what was dropped
      fault_r <= avs_writedata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frame_r <= 32'h0000_0000;
    end else if (wr_take && avs_address == OFS_FRAME) begin
      frame_r <= avs_writedata & FRAME_ALIGN;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      next_ip_r <= 32'h0000_0000;
    end else if (wr_take && avs_address == OFS_NEXTIP) begin
      next_ip_r <= avs_writedata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      entry_r <= 32'h0000_0000;
    end else if (wr_take && avs_address == OFS_ENTRY) begin
      // Call form rides in the two low bits of the word aligned start
      entry_r <= avs_writedata;
    end
  end

  // ---------------------------------------------------------------
  // Configuration word catch after reset
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      unal_mask_r  <= 1'b0;
      cfg_loaded_r <= 1'b0;
    end else if (wr_take && avs_address == OFS_CFGWORD && !cfg_loaded_r) begin
      // Taken once only, as at initialization
      unal_mask_r  <= avs_writedata[UNAL_MASK_BIT];
      cfg_loaded_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Control register and its restore on return
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 32'h0000_0000;
    end else if (go_fault && raise) begin
      ctrl_r <= ctrl_r;
    end else if (state_r == ST_SAVE) begin
      ctrl_r[BIT_SUPER_MODE] <= entry_r[1:0] == CALL_SYS_SUPER ||
                                ctrl_r[BIT_SUPER_MODE];
      if (cls.is_trace)
        ctrl_r[BIT_TRACE_EN] <= 1'b0;
    end else if (go_ret) begin
      ctrl_r[BIT_NO_IMPREC] <= saved_ctrl_r[BIT_NO_IMPREC];
      ctrl_r[BIT_OVF_MASK]  <= saved_ctrl_r[BIT_OVF_MASK];
      if (ctrl_r[BIT_SUPER_MODE]) begin
        // Handler edits to process controls are lost here
        ctrl_r[BIT_TRACE_EN]   <= saved_ctrl_r[BIT_TRACE_EN];
        ctrl_r[BIT_SUPER_MODE] <= saved_ctrl_r[BIT_SUPER_MODE];
      end
    end else if (wr_take && avs_address == OFS_CTRL) begin
      ctrl_r <= avs_writedata;
    end
  end

  // ---------------------------------------------------------------
  // Dispatch sequence
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE:    if (go_fault && raise) state_r <= ST_SAVE;
        ST_SAVE:    state_r <= ST_HANDLER;
        ST_HANDLER: if (go_ret) state_r <= ST_RETURN;
        ST_RETURN:  state_r <= ST_IDLE;
        default:    state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame link written by the fault call
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_frame_r <= 32'h0000_0000;
      ret_type_r   <= 3'b000;
    end else if (state_r == ST_SAVE) begin
      prev_frame_r <= frame_r;
      ret_type_r   <= RET_FAULT;
    end else if (go_ret) begin
      ret_type_r   <= 3'b000;
    end
  end

  // ---------------------------------------------------------------
  // Saved return pointer and its validity
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      saved_return_pointer <= 32'h0000_0000;
      rip_valid_r          <= 1'b0;
    end else if (state_r == ST_SAVE) begin
      saved_return_pointer <= rip_calc;
      rip_valid_r          <= cls.rip_valid;
    end else if (state_r == ST_HANDLER && wr_take && avs_address == OFS_PREV_PTR) begin
      // Handler moves the resume point itself
      saved_return_pointer <= avs_writedata;
      rip_valid_r          <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Controls image and pending trace of the fault record
  // ---------------------------------------------------------------
  // Taken before the call edits supervisor and trace bits
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      saved_ctrl_r <= 32'h0000_0000;
    end else if (state_r == ST_SAVE) begin
      saved_ctrl_r <= ctrl_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pending_trace_r <= 1'b0;
    end else if (state_r == ST_SAVE) begin
      pending_trace_r <= cls.is_trace;
    end else if (go_ret) begin
      pending_trace_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Fault acceptance flags
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      imprecise_sync_r <= 1'b0;
    end else if (go_fault) begin
      imprecise_sync_r <= is_imprecise(avs_writedata[TYPE_LSB +: TYPE_W]) &&
                          ctrl_r[BIT_NO_IMPREC];
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dropped_r <= 1'b0;
    end else if (go_fault) begin
      dropped_r <= !raise;
    end
  end

  // ---------------------------------------------------------------
  // Commit and call outputs
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dispatch_r <= 1'b0;
    end else begin
      dispatch_r <= state_r == ST_SAVE;
    end
  end

  // Held back through ST_HANDLER and the ST_RETURN cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      commit_dest_r <= 1'b1;
      commit_mem_r  <= 1'b1;
    end else if (state_r == ST_SAVE) begin
      commit_dest_r <= !cls.kill_dest;
      commit_mem_r  <= cls.when_fault != WHEN_BEFORE;
    end else if (state_r == ST_RETURN) begin
      commit_dest_r <= 1'b1;
      commit_mem_r  <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      handler_super_r <= 1'b0;
    end else if (state_r == ST_SAVE) begin
      handler_super_r <= entry_r[1:0] == CALL_SYS_SUPER;
    end else if (state_r == ST_RETURN) begin
      handler_super_r <= 1'b0;
    end
  end
endmodule

// ### rtl/fault_pkg.sv
package fault_pkg;
  // ---------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W         = 4;
  localparam logic [3:0]  OFS_CTRL       = 4'h0;
  localparam logic [3:0]  OFS_FAULT      = 4'h1;
  localparam logic [3:0]  OFS_STATUS     = 4'h2;
  localparam logic [3:0]  OFS_FRAME      = 4'h3;
  localparam logic [3:0]  OFS_PREV_PTR   = 4'h4;
  localparam logic [3:0]  OFS_NEXTIP     = 4'h5;
  localparam logic [3:0]  OFS_ENTRY      = 4'h6;
  localparam logic [3:0]  OFS_RET        = 4'h7;
  localparam logic [3:0]  OFS_CFGWORD    = 4'h8;
  localparam logic [31:0] UNMAPPED_DATA  = 32'hDEADBEEF;

  // ---------------------------------------------------------------
  // Control bit positions (CTRL register; UNAL_MASK_BIT is a bit of the configuration word)
  // ---------------------------------------------------------------
  localparam int BIT_OVF_MASK   = 0;
  localparam int BIT_NO_IMPREC  = 1;
  localparam int BIT_TRACE_EN   = 2;
  localparam int BIT_SUPER_MODE = 3;
  localparam int TMODE_LSB      = 8;
  localparam int TMODE_W        = 8;
  localparam int UNAL_MASK_BIT  = 30;

  // ---------------------------------------------------------------
  // Fault command word (FAULT register)
  // ---------------------------------------------------------------
  localparam int SUB_LSB  = 8;
  localparam int SUB_W    = 8;
  localparam int TYPE_LSB = 0;
  localparam int TYPE_W   = 8;
  localparam int TM_LSB   = 16;

  localparam logic [7:0] FT_TRACE      = 8'h01;
  localparam logic [7:0] FT_OPERATION  = 8'h02;
  localparam logic [7:0] FT_ARITH      = 8'h03;
  localparam logic [7:0] FT_CONSTRAINT = 8'h05;
  localparam logic [7:0] FT_PROTECT    = 8'h07;
  localparam logic [7:0] FT_TYPE       = 8'h0A;

  localparam logic [7:0] SUB_OVERFLOW   = 8'h01;
  localparam logic [7:0] SUB_ZERO_DIV   = 8'h02;
  localparam logic [7:0] SUB_UNALIGNED  = 8'h05;
  localparam logic [7:0] SUB_RANGE      = 8'h01;
  localparam logic [7:0] SUB_LENGTH     = 8'h02;
  localparam logic [7:0] SUB_MISMATCH   = 8'h01;
  localparam logic [7:0] SUB_HW_BREAK   = 8'h40;
  localparam logic [7:0] SUB_MARK       = 8'h80;

  // ---------------------------------------------------------------
  // Call forms, return code, frame layout
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CALL_LOCAL        = 2'b00,
    CALL_SYS_LOCAL    = 2'b10,
    CALL_SYS_SUPER    = 2'b11
  } call_type;
  localparam logic [2:0]  RET_FAULT      = 3'b001;
  localparam logic [31:0] RET_PTR_OFS    = 32'h0000_0008;
  localparam logic [31:0] CFG_WORD_OFS   = 32'h0000_000C;
  localparam logic [31:0] WORD_MASK      = 32'h0000_0003;
  localparam logic [31:0] FRAME_ALIGN    = 32'hFFFF_FFF0;

  typedef enum logic [1:0] {
    WHEN_BEFORE = 2'b00,
    WHEN_DURING = 2'b01,
    WHEN_AFTER  = 2'b10
  } when_type;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAVE    = 2'b01,
    ST_HANDLER = 2'b11,
    ST_RETURN  = 2'b10
  } state_type;
endpackage

// ### rtl/fault_rip_calc.sv
`timescale 1ns/100ps
module fault_rip_calc (
  input  wire logic        sel_next,
  input  wire logic [31:0] fault_ip,
  input  wire logic [31:0] next_ip,
  output logic      [31:0] rip
);
  // ---------------------------------------------------------------
  // Saved pointer choice
  // ---------------------------------------------------------------
  always_comb begin
    rip = sel_next ? next_ip : fault_ip;
  end
endmodule

// ### tb/fault_dispatch_and_resume_test.sv
`timescale 1ns/100ps
module fault_dispatch_and_resume_test;
  import fault_pkg::*;
  localparam logic [31:0] TE_ON = 32'h0000_0004;
  localparam logic [31:0] NIP   = 32'h0000_1A40;
  typedef struct packed {
    logic [7:0] ty;
    logic [7:0] sb;
    logic       rv;
    logic       dst;
    logic       nip;
  } row_type;
  logic              mclk;
  logic              rst_b;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              commit_dest_r;
  logic              commit_mem_r;
  logic              handler_super_r;
  logic              dispatch_r;
  logic [31:0]       rd;
  int                bad_count;
  int                tests_run;
  int                cycles;
  row_type           rows [8];
  fault_dispatch dut_u (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .commit_dest_r(commit_dest_r), .commit_mem_r(commit_mem_r),
    .handler_super_r(handler_super_r), .dispatch_r(dispatch_r));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle edge first, so no strobe is lowered and raised in one step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      chk(32'h0, 32'h1);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic fault(input logic [31:0] ctrl, input logic [7:0] ty, input logic [7:0] sb,
                       input logic [7:0] tev, input logic exp);
    logic seen;
    seen = 1'b0;
    bus(1'b1, OFS_CTRL, ctrl);
    bus(1'b1, OFS_NEXTIP, NIP);
    bus(1'b1, OFS_FAULT, {8'h00, tev, sb, ty});
    repeat (12) begin
      @(posedge mclk);
      if (dispatch_r === 1'b1)
        seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, exp});
  endtask
  task automatic ret_idle();
    bus(1'b1, OFS_RET, 32'h0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, {30'h0, ST_IDLE});
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      end_of_test();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    rows[0] = '{FT_ARITH, SUB_ZERO_DIV, 1'b1, 1'b0, 1'b0};
    rows[1] = '{FT_TYPE, SUB_MISMATCH, 1'b0, 1'b0, 1'b0};
    rows[2] = '{FT_PROTECT, SUB_LENGTH, 1'b0, 1'b0, 1'b0};
    rows[3] = '{FT_OPERATION, 8'h03, 1'b0, 1'b0, 1'b0};
    rows[4] = '{FT_OPERATION, SUB_UNALIGNED, 1'b0, 1'b1, 1'b0};
    rows[5] = '{FT_CONSTRAINT, SUB_RANGE, 1'b0, 1'b1, 1'b0};
    rows[6] = '{FT_ARITH, SUB_OVERFLOW, 1'b1, 1'b1, 1'b1};
    rows[7] = '{FT_TRACE, SUB_MARK, 1'b1, 1'b1, 1'b1};
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    chk({30'h0, commit_dest_r, commit_mem_r}, 32'h3);
    chk({30'h0, handler_super_r, dispatch_r}, 32'h0);
    foreach (rows[i]) begin
      fault(TE_ON, rows[i].ty, rows[i].sb, 8'h00, 1'b1);
      chk({31'h0, commit_dest_r}, {31'h0, rows[i].dst});
      chk({31'h0, commit_mem_r}, {31'h0, rows[i].dst});
      bus(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rd[5]}, {31'h0, rows[i].rv});
      chk({29'h0, rd[4:2]}, {29'h0, RET_FAULT});
      bus(1'b0, OFS_RET, 32'h0);
      if (rows[i].nip)
        chk(rd, NIP);
      ret_idle();
    end
    bus(1'b0, 4'hF, 32'h0);
    chk(rd, UNMAPPED_DATA);
    fault(TE_ON | 32'h1, FT_ARITH, SUB_OVERFLOW, 8'h00, 1'b0);
    fault(32'h0, FT_TRACE, 8'h02, 8'h01, 1'b0);
    fault(TE_ON | 32'h0000_0200, FT_TRACE, 8'h02, 8'h01, 1'b0);
    fault(TE_ON | 32'h0000_0100, FT_TRACE, 8'h02, 8'h01, 1'b1);
    ret_idle();
    fault(TE_ON, FT_TRACE, SUB_HW_BREAK, 8'h00, 1'b1);
    ret_idle();
    bus(1'b1, OFS_ENTRY, 32'h0000_4A00 | {30'h0, CALL_SYS_SUPER});
    fault(32'h0, FT_ARITH, SUB_OVERFLOW, 8'h00, 1'b1);
    chk({31'h0, handler_super_r}, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h0000_000F);
    ret_idle();
    bus(1'b0, OFS_CTRL, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h0);
    bus(1'b1, OFS_ENTRY, 32'h0000_4B00 | {30'h0, CALL_SYS_LOCAL});
    fault(32'h0, FT_ARITH, SUB_OVERFLOW, 8'h00, 1'b1);
    chk({31'h0, handler_super_r}, 32'h0);
    bus(1'b1, OFS_CTRL, TE_ON);
    ret_idle();
    bus(1'b0, OFS_CTRL, 32'h0);
    chk({28'h0, rd[3:0]}, TE_ON);
    fault(32'h0000_0002, FT_CONSTRAINT, SUB_RANGE, 8'h00, 1'b1);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[8]}, 32'h1);
    bus(1'b1, OFS_PREV_PTR, 32'h0000_2000);
    bus(1'b0, OFS_RET, 32'h0);
    chk(rd, 32'h0000_2000);
    ret_idle();
    bus(1'b1, OFS_CFGWORD, 32'h4000_0000);
    fault(32'h0, FT_OPERATION, SUB_UNALIGNED, 8'h00, 1'b0);
    fault(32'h0, FT_ARITH, SUB_ZERO_DIV, 8'h00, 1'b1);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({30'h0, commit_dest_r, commit_mem_r}, 32'h3);
    rst_b <= 1'b1;
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({30'h0, rd[1:0]}, {30'h0, ST_IDLE});
    end_of_test();
  end
endmodule

// ### tb/fault_dispatch_checker.sv
`timescale 1ns/100ps
module fault_dispatch_checker
  import fault_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              commit_dest_r,
  input wire logic              commit_mem_r,
  input wire logic              handler_super_r,
  input wire logic              dispatch_r
);
  // ---------------------------------------------------------------
  // Cycles since last write, saturating so it never wraps
  // ---------------------------------------------------------------
  logic [3:0] wr_age_r;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      wr_age_r <= 4'hF;
    else if (avs_write)
      wr_age_r <= 4'h0;
    else if (wr_age_r != 4'hF)
      wr_age_r <= wr_age_r + 4'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access waited more than one cycle");
  a_idle_wait_high: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low after an idle cycle");
  a_first_wait: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
    |-> avs_waitrequest) else $error("new access not held for a cycle");
  a_unmapped_read: assert property (avs_read && avs_address == 4'hF && avs_waitrequest
    |=> avs_readdata == UNMAPPED_DATA) else $error("unmapped read data wrong");
  a_readdata_holds: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_dispatch_pulse: assert property (dispatch_r |=> !dispatch_r [*3])
    else $error("dispatch pulse too long");
  a_dispatch_cause: assert property ($rose(dispatch_r) |-> wr_age_r <= 4'h4)
    else $error("dispatch without recent write");
  a_drop_mem_too: assert property (!commit_dest_r |-> !commit_mem_r)
    else $error("memory update kept while result dropped");
  a_outputs_settle: assert property (!avs_write [*5]
    |=> $stable({commit_dest_r, commit_mem_r, handler_super_r}))
    else $error("fault outputs moved without a write");
  c_dispatch: cover property (dispatch_r);
  c_dropped: cover property (dispatch_r && !commit_dest_r);
  c_super: cover property ($rose(handler_super_r));
endmodule
bind fault_dispatch fault_dispatch_checker chk_u (.mclk(mclk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .commit_dest_r(commit_dest_r),
  .commit_mem_r(commit_mem_r), .handler_super_r(handler_super_r), .dispatch_r(dispatch_r));
